// ### src/psram_burst_pkg.sv
// constants, pin layout and state type of the synchronous burst port
package psram_burst_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int ADDR_W    = 23;         // word address pins
  localparam int DATA_W    = 16;         // data pins
  localparam int MEM_AW    = 8;          // index bits of the modelled array
  localparam int MEM_DEPTH = 1 << MEM_AW;

  // ****************************************************************
  // burst configuration
  // ****************************************************************
  localparam logic [3:0] LATENCY      = 4'h5;  // link clocks to first data
  localparam logic [3:0] WAIT_RDY_CNT = 4'h4;  // latency minus one
  localparam logic [1:0] LAST_BEAT    = 2'h3;  // burst length 4, last index

  // ****************************************************************
  // timing of the far side, in ns and core cycles
  // ****************************************************************
  localparam int CORE_CLK_NS          = 8;
  localparam int BURST_CYCLE_TIME_NS  = 2500;
  localparam int BURST_CYCLE_CYCLES   = BURST_CYCLE_TIME_NS / CORE_CLK_NS;
  localparam int BURST_STOP_TIME_NS   = 2500;
  localparam int BURST_STOP_CYCLES    = BURST_STOP_TIME_NS / CORE_CLK_NS;
  localparam int BURST_END_GAP_NS     = 7;
  localparam int BURST_END_GAP_CYC    = (BURST_END_GAP_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int BURST_STOP_GAP_NS    = 12;
  localparam int BURST_STOP_GAP_CYC   = (BURST_STOP_GAP_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int BYTE_EN_LEAD_CLOCKS  = 1;
  localparam int OUT_EN_LEAD_CLOCKS   = 1;

  // ****************************************************************
  // layout of the sampled pin vector
  // ****************************************************************
  localparam int POS_DQ   = 0;
  localparam int POS_ADDR = POS_DQ + DATA_W;
  localparam int POS_MRS  = POS_ADDR + ADDR_W;
  localparam int POS_LB   = POS_MRS + 1;
  localparam int POS_UB   = POS_LB + 1;
  localparam int POS_OE   = POS_UB + 1;
  localparam int POS_WE   = POS_OE + 1;
  localparam int POS_ADV  = POS_WE + 1;
  localparam int POS_CS   = POS_ADV + 1;
  localparam int POS_CLK  = POS_CS + 1;
  localparam int PIN_W    = POS_CLK + 1;
  localparam logic [PIN_W-1:0] PIN_RST = '1;   // all pins idle high at reset

  // ****************************************************************
  // burst sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_LAT, ST_DATA, ST_HOLD} burst_state_e;

endpackage

// ### src/link_pins_if.sv
// sampled link pins passed from the pin sampler to the burst core
`timescale 1ns/1ps
interface link_pins_if;
  import psram_burst_pkg::*;

  logic              clk_rise;   // one-cycle pulse on link clock rising
  logic              cs_fall;    // one-cycle pulse on chip select falling
  logic              adv_fall;   // one-cycle pulse on address strobe falling
  logic              cs_n;       // filtered chip select
  logic              adv_n;      // filtered address strobe
  logic              we_n;       // filtered write enable
  logic              oe_n;       // filtered output enable
  logic              ub_n;       // filtered upper byte enable
  logic              lb_n;       // filtered lower byte enable
  logic              mrs_n;      // filtered mode register pin
  logic [ADDR_W-1:0] addr;       // filtered address
  logic [DATA_W-1:0] dq;         // filtered write data

  modport sampler (output clk_rise, cs_fall, adv_fall, cs_n, adv_n, we_n, oe_n,
                   ub_n, lb_n, mrs_n, addr, dq);
  modport core    (input  clk_rise, cs_fall, adv_fall, cs_n, adv_n, we_n, oe_n,
                   ub_n, lb_n, mrs_n, addr, dq);
endinterface

// ### src/link_pin_sampler.sv
// three-stage pin synchronisers with agreement filter and edge pulses
`timescale 1ns/1ps
module link_pin_sampler (
  // clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          rstn_i,
  // raw pins, packed by the pin layout
  input  wire logic [psram_burst_pkg::PIN_W-1:0] pins_i,
  // filtered pins toward the core
  link_pins_if.sampler                       lnk
);
  import psram_burst_pkg::*;

  logic [PIN_W-1:0] sync1;     // first stage, read only by sync2
  logic [PIN_W-1:0] sync2;     // second stage
  logic [PIN_W-1:0] sync3;     // third stage
  logic [PIN_W-1:0] filt;      // accepted pin level
  logic [PIN_W-1:0] filt_d;    // accepted level one cycle back

  // ****************************************************************
  // per-bit synchroniser
  // ****************************************************************
  genvar b;
  generate
    for (b = 0; b < PIN_W; b++) begin : g_bit
      // a change counts once stages two and three agree
      always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
          sync1[b] <= PIN_RST[b];
          sync2[b] <= PIN_RST[b];
          sync3[b] <= PIN_RST[b];
          filt[b]  <= PIN_RST[b];
        end else begin
          sync1[b] <= pins_i[b];
          sync2[b] <= sync1[b];
          sync3[b] <= sync2[b];
          if (sync2[b] == sync3[b]) begin
            filt[b] <= sync3[b];
          end
        end
      end
    end
  endgenerate

  // history for edge detection
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      filt_d <= PIN_RST;
    end else begin
      filt_d <= filt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign lnk.clk_rise = filt[POS_CLK] & ~filt_d[POS_CLK];
  assign lnk.cs_fall  = ~filt[POS_CS] & filt_d[POS_CS];
  assign lnk.adv_fall = ~filt[POS_ADV] & filt_d[POS_ADV];
  assign lnk.cs_n     = filt[POS_CS];
  assign lnk.adv_n    = filt[POS_ADV];
  assign lnk.we_n     = filt[POS_WE];
  assign lnk.oe_n     = filt[POS_OE];
  assign lnk.ub_n     = filt[POS_UB];
  assign lnk.lb_n     = filt[POS_LB];
  assign lnk.mrs_n    = filt[POS_MRS];
  assign lnk.addr     = filt[POS_ADDR +: ADDR_W];
  assign lnk.dq       = filt[POS_DQ +: DATA_W];

endmodule

// ### src/sync_burst_psram_port.sv
// synchronous burst read and write port of a pseudo-static ram
`timescale 1ns/1ps
module sync_burst_psram_port (
  // core clock and reset
  input  wire logic                                core_clk_i,
  input  wire logic                                rstn_i,
  // link control pins from the controller
  input  wire logic                                burst_clk_i,
  input  wire logic                                cs_n_i,
  input  wire logic                                addr_valid_n_i,
  input  wire logic                                we_n_i,
  input  wire logic                                oe_n_i,
  input  wire logic                                upper_byte_en_n_i,
  input  wire logic                                lower_byte_en_n_i,
  input  wire logic                                mode_reg_set_n_i,
  input  wire logic [psram_burst_pkg::ADDR_W-1:0]  addr_i,
  // data pins, three signals of one two-way bus
  input  wire logic [psram_burst_pkg::DATA_W-1:0]  dq_i,
  output logic      [psram_burst_pkg::DATA_W-1:0]  dq_o,
  output logic                                     dq_oe_n_o,
  // wait indicator, low means data not available
  output logic                                     wait_n_o,
  output logic                                     wait_oe_n_o
);
  import psram_burst_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  burst_state_e      state;               // burst sequencer state
  logic [3:0]        lat_cnt;             // link clock edges since start
  logic [1:0]        beat;                // word index inside the burst
  logic [ADDR_W-1:0] base_addr;           // address latched at start
  logic              is_write;            // burst direction, high for write
  logic              adv_used;            // current strobe period already started
  logic              wait_lvl;            // wait level, low means not ready
  logic              wait_drive;          // wait pin driven
  logic              start;               // burst start on this cycle
  logic              beat_now;            // a data word moves on this cycle
  logic [MEM_AW-1:0] word_idx;            // array index of the current word
  logic [DATA_W-1:0] mem [0:MEM_DEPTH-1]; // modelled storage array

  link_pins_if lnk ();                    // filtered pins

  // ****************************************************************
  // pin sampling
  // ****************************************************************
  link_pin_sampler u_sampler (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .pins_i     ({burst_clk_i, cs_n_i, addr_valid_n_i, we_n_i, oe_n_i,
                  upper_byte_en_n_i, lower_byte_en_n_i, mode_reg_set_n_i,
                  addr_i, dq_i}),
    .lnk        (lnk)
  );

  // ****************************************************************
  // burst start and beat decode
  // ****************************************************************
  // at most one link clock edge of a strobe low period starts a burst,
  // and only while the mode pin is inactive and no burst is running
  assign start = lnk.clk_rise & ~lnk.cs_n & ~lnk.adv_n & ~adv_used
               & lnk.mrs_n
               & ((state == ST_IDLE) | (state == ST_HOLD));

  // a word moves only on a link clock edge, so a halted clock freezes all
  assign beat_now = lnk.clk_rise & ~lnk.cs_n
                  & (((state == ST_LAT) & (lat_cnt == (LATENCY - 4'h1)))
                     | (state == ST_DATA));

  // linear burst address from the latched base
  assign word_idx = base_addr[MEM_AW-1:0] + MEM_AW'(beat);

  // ****************************************************************
  // strobe period tracking
  // ****************************************************************
  // blocks further starts until the strobe returns high,
  // so extra link rises under one strobe are not taken as new commands
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      adv_used <= 1'b0;
    end else if (lnk.adv_n || lnk.cs_n) begin
      adv_used <= 1'b0;
    end else if (start) begin
      adv_used <= 1'b1;
    end
  end

  // ****************************************************************
  // burst sequencer
  // ****************************************************************
  // counts latency edges, walks four beats, then holds the last word;
  // a refused strobe leaves the running burst untouched
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state     <= ST_IDLE;
      lat_cnt   <= 4'h0;
      beat      <= 2'h0;
      base_addr <= '0;
      is_write  <= 1'b0;
    end else if (lnk.cs_n) begin
      // chip select high stops any burst at once
      state   <= ST_IDLE;
      lat_cnt <= 4'h0;
      beat    <= 2'h0;
    end else if (start) begin
      // command clock: latch address and direction
      state     <= ST_LAT;
      lat_cnt   <= 4'h1;
      beat      <= 2'h0;
      base_addr <= lnk.addr;
      is_write  <= ~lnk.we_n;
    end else if (lnk.clk_rise) begin
      unique case (state)
        ST_IDLE: begin
          state <= ST_IDLE;
        end
        ST_LAT: begin
          // the latency edge itself carries the first word
          lat_cnt <= lat_cnt + 4'h1;
          if (lat_cnt == (LATENCY - 4'h1)) begin
            state <= ST_DATA;
            beat  <= 2'h1;
          end
        end
        ST_DATA: begin
          // address advances here and at the latency edge in ST_LAT, always on a real clock edge
          if (beat == LAST_BEAT) begin
            state <= ST_HOLD;
          end else begin
            beat <= beat + 2'h1;
          end
        end
        ST_HOLD: begin
          // burst length delivered, keep the last word
          state <= ST_HOLD;
        end
      endcase
    end
  end

  // ****************************************************************
  // wait indicator
  // ****************************************************************
  // not ready on select or strobe fall, ready from latency minus one
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wait_lvl <= 1'b0;
    end else if (lnk.cs_fall || lnk.adv_fall || start) begin
      wait_lvl <= 1'b0;
    end else if (lnk.clk_rise && !lnk.cs_n && (state == ST_LAT)
                 && (lat_cnt == (WAIT_RDY_CNT - 4'h1))) begin
      wait_lvl <= 1'b1;
    end
  end

  // wait is driven only while the device is selected
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wait_drive <= 1'b0;
    end else begin
      wait_drive <= ~lnk.cs_n;
    end
  end

  // the level keeps its value while released; only the enable moves
  assign wait_n_o    = wait_lvl;
  assign wait_oe_n_o = ~wait_drive;

  // ****************************************************************
  // write path
  // ****************************************************************
  // each byte lane is written only when its enable is low at the beat;
  // the array has no reset, so an unwritten word reads back unknown
  always_ff @(posedge core_clk_i) begin
    if (beat_now && is_write) begin
      if (!lnk.lb_n) begin
        mem[word_idx][7:0] <= lnk.dq[7:0];
      end
      if (!lnk.ub_n) begin
        mem[word_idx][15:8] <= lnk.dq[15:8];
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // the output word changes only on a beat, so a suspend keeps it and
  // the first edge after the clock resumes gives the pending word
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      dq_o <= '0;
    end else if (beat_now && !is_write) begin
      dq_o <= mem[word_idx];
    end
  end

  // data drive needs select, output enable and a word already out
  assign dq_oe_n_o = ~(~lnk.cs_n & ~lnk.oe_n & ~is_write
                       & ((state == ST_DATA) | (state == ST_HOLD)));

endmodule

// ### tb/psram_port_props.sv
// pin-level checks of the synchronous burst port
`timescale 1ns/1ps
module psram_port_props (
  // clock and reset
  input wire logic                               core_clk_i,
  input wire logic                               rstn_i,
  // link pins
  input wire logic                               burst_clk_i,
  input wire logic                               cs_n_i,
  input wire logic                               addr_valid_n_i,
  input wire logic                               oe_n_i,
  input wire logic                               mode_reg_set_n_i,
  // device outputs
  input wire logic [psram_burst_pkg::DATA_W-1:0] dq_o,
  input wire logic                               dq_oe_n_o,
  input wire logic                               wait_n_o,
  input wire logic                               wait_oe_n_o
);
  import psram_burst_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [3:0] rises;  // link rises since the strobe fell
  logic [3:0] age;    // core cycles since select or strobe fell
  // ****************************************************************
  // helper counters
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || $fell(addr_valid_n_i)) begin
      rises <= 4'h0;
    end else if ($rose(burst_clk_i) && rises != 4'hf) begin
      rises <= rises + 4'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i || $fell(cs_n_i) || $fell(addr_valid_n_i)) begin
      age <= 4'h0;
    end else if (age != 4'hf) begin
      age <= age + 4'h1;
    end
  end
  sel_wait_low_a: assert property ($fell(cs_n_i) |-> ##[1:8] !wait_n_o)
    else $error("wait not pulled low after select");
  strobe_wait_low_a: assert property ($fell(addr_valid_n_i) && !cs_n_i |-> ##[1:8] !wait_n_o)
    else $error("wait not pulled low after strobe");
  wait_ready_time_a: assert property ($rose(wait_n_o) |-> rises == 4'h4 && mode_reg_set_n_i)
    else $error("wait went ready at the wrong link rise");
  wait_low_cause_a: assert property ($fell(wait_n_o) |-> age <= 4'h8)
    else $error("wait dropped without select or strobe fall");
  wait_release_a: assert property ($rose(cs_n_i) |-> ##[1:8] wait_oe_n_o)
    else $error("wait not released after deselect");
  wait_idle_off_a: assert property (cs_n_i [*8] |-> wait_oe_n_o)
    else $error("wait driven while deselected");
  dq_off_oe_a: assert property (oe_n_i [*6] |-> dq_oe_n_o)
    else $error("data driven with output enable high");
  dq_off_cs_a: assert property (cs_n_i [*6] |-> dq_oe_n_o)
    else $error("data driven while deselected");
  halt_hold_a: assert property ($stable(burst_clk_i) [*6] |-> $stable(dq_o))
    else $error("read data moved with link clock halted");
  cover property ($rose(wait_n_o));
  cover property (!dq_oe_n_o && $rose(oe_n_i));
  cover property ($rose(cs_n_i) && wait_n_o);
endmodule
bind sync_burst_psram_port psram_port_props props (.core_clk_i, .rstn_i, .burst_clk_i,
  .cs_n_i, .addr_valid_n_i, .oe_n_i, .mode_reg_set_n_i, .dq_o, .dq_oe_n_o, .wait_n_o,
  .wait_oe_n_o);

// ### tb/mem_ctrl_model.sv
// memory controller model driving the burst link pins
`timescale 1ns/1ps
module mem_ctrl_model (
  // core clock
  input  wire logic                               core_clk_i,
  // data wire as seen by the controller
  input  wire logic [psram_burst_pkg::DATA_W-1:0] rdata_i,
  input  wire logic                               rdata_oe_n_i,
  // link pins toward the device
  output logic                                    link_clk_o,
  output logic                                    cs_n_o,
  output logic                                    addr_valid_n_o,
  output logic                                    we_n_o,
  output logic                                    oe_n_o,
  output logic      [1:0]                         byte_en_n_o,
  output logic                                    mode_reg_set_n_o,
  output logic      [psram_burst_pkg::ADDR_W-1:0] addr_o,
  output logic      [psram_burst_pkg::DATA_W-1:0] wdata_o
);
  import psram_burst_pkg::*;
  logic [DATA_W-1:0] wdat [4];  // words to write
  logic [1:0]        wbe  [4];  // lane enables per word, low active
  logic [DATA_W-1:0] rdat [6];  // words read, last two after the burst
  logic [DATA_W-1:0] sus_q;     // data seen during a suspend
  logic              sus_z;     // drive enable seen with oe high in suspend
  logic [DATA_W-1:0] q;         // last sampled wire
  // ****************************************************************
  // link timing
  // ****************************************************************
  initial begin
    {cs_n_o, addr_valid_n_o, we_n_o, oe_n_o, byte_en_n_o} = '1;
    link_clk_o = 1'b0;  // link clock rests low, so the first hi() is a real rise
    {mode_reg_set_n_o, addr_o} = '1;  // mode pin high for bursts
    wdata_o = '0;
  end
  // wait n core edges, then settle just after the edge
  task automatic w(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // high half of a 64 ns link period; pins move at the fall
  task automatic hi();
    link_clk_o = 1'b1;
    w(4);
    link_clk_o = 1'b0;
  endtask
  // low half; the wire is sampled late, once read data has settled
  task automatic lo();
    w(3);
    q = rdata_i;
    w(1);
  endtask
  // one burst, started only after the last ended or stopped
  task automatic burst(input logic wr, input logic [ADDR_W-1:0] a, input int nb,
                       input int susp, input logic keep);
    {cs_n_o, addr_valid_n_o, we_n_o} = {2'b00, ~wr};  // write picked at command clock
    addr_o = a;  // fresh strobe and address each burst
    w(4);
    for (int r = 1; r <= ((nb < 4) ? nb + 4 : 10); r++) begin
      hi();
      if (r == 2) {addr_valid_n_o, we_n_o} = 2'b11;  // strobe held over two rises
      if (!wr && r == 3) {oe_n_o, byte_en_n_o} = 3'b000;  // lead latency end
      wdata_o = (wr && r >= 4 && r < 8) ? wdat[r-4] : ~wdata_o;
      if (wr && r >= 4) byte_en_n_o = (r < 8) ? wbe[r-4] : 2'b11;
      if (r == susp) begin
        oe_n_o = 1'b1;  // clock halted low, bus let go
        w(10);
        sus_z = rdata_oe_n_i;
        oe_n_o = 1'b0;
        w(10);
        sus_q = rdata_i;
      end
      lo();
      if (r >= 5) rdat[r-5] = q;
    end
    {oe_n_o, byte_en_n_o} = 3'b111;  // oe high before any write
    cs_n_o = ~keep;  // deselect ends or stops it well inside 2.5 us
    w(4);  // 32 ns before the next strobe
  endtask
endmodule

// ### tb/tb.sv
// self-checking bench of the synchronous burst port
`timescale 1ns/1ps
module tb;
  import psram_burst_pkg::*;
  logic              core_clk_i, rstn_i, link_clk;  // clocks and reset
  logic              cs_n, adv_n, we_n, oe_n, mrs_n;  // link strobes
  logic [1:0]        be_n;                           // lane enables
  logic [ADDR_W-1:0] addr, ra;                       // link address, random base
  logic [DATA_W-1:0] wdata, dq_q, dq_bus;            // data wire parts
  logic              dq_oe_n, wait_n, wait_oe_n;     // device drive state
  logic [DATA_W-1:0] shadow [MEM_DEPTH];             // expected array
  int                fails, checks_done;
  integer            seed;
  sync_burst_psram_port dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .burst_clk_i(link_clk),
    .cs_n_i(cs_n), .addr_valid_n_i(adv_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .upper_byte_en_n_i(be_n[1]), .lower_byte_en_n_i(be_n[0]), .mode_reg_set_n_i(mrs_n),
    .addr_i(addr), .dq_i(dq_bus), .dq_o(dq_q), .dq_oe_n_o(dq_oe_n), .wait_n_o(wait_n),
    .wait_oe_n_o(wait_oe_n));
  mem_ctrl_model ctl (.core_clk_i(core_clk_i), .rdata_i(dq_bus), .rdata_oe_n_i(dq_oe_n),
    .link_clk_o(link_clk), .cs_n_o(cs_n), .addr_valid_n_o(adv_n), .we_n_o(we_n),
    .oe_n_o(oe_n), .byte_en_n_o(be_n), .mode_reg_set_n_o(mrs_n), .addr_o(addr),
    .wdata_o(wdata));
  // the device wins the wire while it drives, else the controller's pattern
  assign dq_bus = dq_oe_n ? wdata : dq_q;
  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // word after a masked write
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w, new_w,
                                               input logic [1:0] be);
    return {be[1] ? old_w[15:8] : new_w[15:8], be[0] ? old_w[7:0] : new_w[7:0]};
  endfunction
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // write burst of random words; word 2 fully masked unless whole
  task automatic wr_b(input logic [ADDR_W-1:0] a, input int nb, input logic full,
                      input logic keep);
    for (int k = 0; k < 4; k++) begin
      ctl.wdat[k] = 16'($random(seed));
      ctl.wbe[k] = (full || k == 0) ? 2'b00 : ((k == 2) ? 2'b11 : 2'($random(seed)));
    end
    ctl.burst(1'b1, a, nb, 0, keep);
    for (int k = 0; k < nb; k++) begin
      shadow[8'(a + k)] = merge(shadow[8'(a + k)], ctl.wdat[k], ctl.wbe[k]);
    end
  endtask
  // read burst plus two rises of last-word hold, optionally suspended
  task automatic rd_b(input logic [ADDR_W-1:0] a, input int susp, input logic keep);
    ctl.burst(1'b0, a, 4, susp, keep);
    for (int k = 0; k < 6; k++) begin
      chk(ctl.rdat[k], shadow[8'(a + ((k > 3) ? 3 : k))]);
    end
    if (susp > 0) begin
      chk({15'h0, ctl.sus_z}, 16'h0001);
      chk(ctl.sus_q, shadow[8'(a + susp - 5)]);
    end
  endtask
  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    seed = 32'h8dd0;
    rstn_i = 1'b0;
    repeat (12) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    ctl.w(4);
    wr_b(23'h0000fe, 4, 1'b1, 1'b0);  // whole words across the array wrap
    rd_b(23'h0000fe, 0, 1'b0);
    chk({15'h0, wait_n}, 16'h0001);
    wr_b(23'h0000fe, 4, 1'b0, 1'b1);  // masked words, select held after
    rd_b(23'h0000fe, 6, 1'b0);  // back to back, then suspended
    wr_b(23'h0000fe, 2, 1'b0, 1'b0);  // write stopped after two words
    ctl.burst(1'b0, 23'h0000fe, 1, 0, 1'b0);  // read stopped after one word
    rd_b(23'h0000fe, 0, 1'b0);
    ctl.mode_reg_set_n_o = 1'b0;
    ctl.w(4);
    ctl.burst(1'b0, 23'h000040, 4, 0, 1'b0);  // refused while the mode pin is low
    ctl.w(2);  // let the deselect pass the pin filter
    chk(dq_q, shadow[8'h01]);
    chk({15'h0, dq_oe_n}, 16'h0001);
    chk({15'h0, wait_n}, 16'h0000);
    chk({15'h0, wait_oe_n}, 16'h0001);
    ctl.mode_reg_set_n_o = 1'b1;
    ctl.w(4);
    repeat (4) begin
      ra = 23'($random(seed));
      wr_b(ra, 4, 1'b1, 1'b0);
      wr_b(ra, 4, 1'b0, 1'b1);
      rd_b(ra, 5 + ($random(seed) & 3), 1'b0);
    end
    end_sim();
  end
  initial begin
    #100000;
    fails++;
    end_sim();
  end
endmodule
